// file: ccx_pkg.sv
// package for the call/clear instruction executor: opcodes, widths, register map
// assumes a 14-bit instruction word and a 15-bit instruction pointer
package ccx_pkg;
    localparam int          IW = 14;
    localparam int          PW = 15;
    // instruction encodings (14-bit)
    localparam logic [13:0] OP_CALL_MASK  = 14'h3800;
    localparam logic [13:0] OP_CALL       = 14'h2000;
    localparam logic [13:0] OP_CALL_ACC   = 14'h000a;
    localparam logic [13:0] OP_WDKICK     = 14'h0064;
    localparam logic [13:0] OP_ZACC       = 14'h0100;
    localparam logic [13:0] OP_ZACC_MASK  = 14'h3f80;
    localparam logic [13:0] OP_ZFILE      = 14'h0180;
    localparam logic [13:0] OP_ZFILE_MASK = 14'h3f80;
    localparam logic [13:0] OP_FOP_MASK   = 14'h3f00;
    localparam logic [13:0] OP_INV        = 14'h0900;
    localparam logic [13:0] OP_DEC        = 14'h0300;
    localparam int          DEST_BIT      = 7;
    // axi register byte addresses
    localparam logic [7:0]  A_INSTR  = 8'h00;
    localparam logic [7:0]  A_ACC    = 8'h04;
    localparam logic [7:0]  A_LATCH  = 8'h08;
    localparam logic [7:0]  A_PTR    = 8'h0c;
    localparam logic [7:0]  A_STATUS = 8'h10;
    localparam logic [7:0]  A_STACK  = 8'h14;
    localparam logic [7:0]  A_FDATA  = 8'h18;
    localparam logic [7:0]  A_WATCHDOG = 8'h1c;
    localparam logic [7:0]  A_FADDR  = 8'h20;
    // status field positions
    localparam int          ST_Z  = 2;
    localparam int          ST_SLEEP   = 3;
    localparam int          ST_EXPIRED = 4;
    localparam int          ST_BUSY = 8;
    localparam logic [1:0]  RESP_OK  = 2'b00;
    localparam logic [1:0]  RESP_ERR = 2'b10;
    localparam int          CALL_CYCLES = 2;
endpackage : ccx_pkg

// file: ccx_wdt.sv
// watchdog counter with its own prescaler
// assumes one clear pulse per kick instruction
`timescale 1ns/10ps
module ccx_watchdog #(
    parameter int PRE_W = 8,
    parameter int CNT_W = 16
) (
    input  wire logic             i_mclk,
    input  wire logic             i_reset_n,
    input  wire logic             i_clear,
    output logic      [CNT_W-1:0] o_count
);
    logic [PRE_W-1:0] pre_r;
    logic [CNT_W-1:0] cnt_r;
    wire              pre_wrap = &pre_r;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pre_r <= '0;
            cnt_r <= '0;
        end else if (i_clear) begin
            pre_r <= '0;
            cnt_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
            if (pre_wrap)
                cnt_r <= cnt_r + 1'b1;
        end
    end
    assign o_count = cnt_r;
endmodule : ccx_watchdog

// file: ccx_exec.sv
// executor for call, watchdog kick, clear, complement and decrement instructions
// software issues instructions over axi4-lite; file register space is local
// Function
// - literal call pushes pointer plus one
// - literal call builds pointer from literal, latch
// - literal call two cycles, flags unchanged
// - accumulator call pushes pointer plus one in the same cycle as the load
// - accumulator call pointer from accumulator, latch
// - accumulator call two cycles, flags unchanged
// - kick clears watchdog, sets both flags
// - file clear writes zero, sets zero
// - accumulator clear writes zero, sets zero
// - complement file, destination by select bit
// - decrement file, destination by select bit
`timescale 1ns/10ps
module ccx_exec #(
    parameter int NREG = 128
) (
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic [14:0]      o_instruction_pointer,
    output logic             o_busy
);
    typedef enum logic [1:0] {CCX_IDLE = 2'b00, CCX_EXEC = 2'b01, CCX_CALL2 = 2'b11} ccx_state_e;

    ccx_state_e  st_r;
    logic [13:0] ir_r;
    logic [7:0]  acc_r;
    logic [6:0]  latch_r;
    logic [14:0] ptr_r;
    logic [14:0] stack_top_r;
    logic        z_r;
    logic        expired_r;
    logic        sleep_r;
    logic [6:0]  faddr_r;
    logic [7:0]  freg_r [NREG];
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [15:0] watchdog_count;

    // decode
    wire         is_call  = (ir_r & ccx_pkg::OP_CALL_MASK) == ccx_pkg::OP_CALL;
    wire         is_call_acc = ir_r == ccx_pkg::OP_CALL_ACC;
    wire         is_kick  = ir_r == ccx_pkg::OP_WDKICK;
    wire         is_zacc  = (ir_r & ccx_pkg::OP_ZACC_MASK) == ccx_pkg::OP_ZACC;
    wire         is_zfile = (ir_r & ccx_pkg::OP_ZFILE_MASK) == ccx_pkg::OP_ZFILE;
    wire         is_inv   = (ir_r & ccx_pkg::OP_FOP_MASK) == ccx_pkg::OP_INV;
    wire         is_dec   = (ir_r & ccx_pkg::OP_FOP_MASK) == ccx_pkg::OP_DEC;
    wire         to_file  = ir_r[ccx_pkg::DEST_BIT];
    wire [6:0]   f_idx    = ir_r[6:0];
    wire [7:0]   f_val    = freg_r[f_idx];
    wire [7:0]   inv_res  = ~f_val;
    wire [7:0]   dec_res  = f_val - 8'h01;
    wire [7:0]   fop_res  = is_inv ? inv_res : dec_res;
    wire         fop      = is_inv | is_dec;
    wire [14:0]  call_tgt  = {latch_r[6:3], ir_r[10:0]};
    wire [14:0]  call_acc_tgt = {latch_r, acc_r};
    // both call forms share the push and the second cycle
    wire         is_any_call = is_call | is_call_acc;
    wire         exec_go  = (st_r == CCX_EXEC);
    wire         kick     = exec_go & is_kick;

    // axi write decode
    wire         aw_hs    = i_awvalid & o_awready;
    wire         w_hs     = i_wvalid & o_wready;
    wire         aw_have  = aw_got_r | aw_hs;
    wire         w_have   = w_got_r | w_hs;
    wire [7:0]   wa       = aw_got_r ? awaddr_r : i_awaddr;
    wire [31:0]  wd       = w_got_r ? wdata_r : i_wdata;
    wire [3:0]   ws       = w_got_r ? wstrb_r : i_wstrb;
    wire         wr_fire  = aw_have & w_have & ~bvalid_r;
    wire         wr_idle  = (st_r == CCX_IDLE);
    wire         wa_instr = wa == ccx_pkg::A_INSTR;
    wire         wa_acc   = wa == ccx_pkg::A_ACC;
    wire         wa_latch = wa == ccx_pkg::A_LATCH;
    wire         wa_fdata = wa == ccx_pkg::A_FDATA;
    wire         wa_faddr = wa == ccx_pkg::A_FADDR;
    wire         wa_ok    = wa_instr | wa_acc | wa_latch | wa_fdata | wa_faddr;
    // mapped writes stall while an instruction runs so state never races the executor
    wire         wr_do    = wr_fire & wr_idle & wa_ok;
    // unmapped writes are answered at once, even while an instruction runs
    wire         wr_take  = wr_fire & (wr_idle | ~wa_ok);

    assign o_awready = ~aw_got_r & ~bvalid_r;
    assign o_wready  = ~w_got_r & ~bvalid_r;
    assign o_bvalid  = bvalid_r;
    assign o_bresp   = bresp_r;

    // axi read decode
    wire         ar_hs    = i_arvalid & o_arready;
    // status word placed by the package field positions
    logic [31:0] status_w;
    always_comb begin
        status_w                      = 32'h0;
        status_w[ccx_pkg::ST_Z]       = z_r;
        status_w[ccx_pkg::ST_SLEEP]   = sleep_r;
        status_w[ccx_pkg::ST_EXPIRED] = expired_r;
        status_w[ccx_pkg::ST_BUSY]    = ~wr_idle;
    end
    wire [7:0]   ra       = i_araddr;
    wire         ra_ok    = (ra == ccx_pkg::A_INSTR) | (ra == ccx_pkg::A_ACC) | (ra == ccx_pkg::A_LATCH)
                          | (ra == ccx_pkg::A_PTR) | (ra == ccx_pkg::A_STATUS) | (ra == ccx_pkg::A_STACK)
                          | (ra == ccx_pkg::A_FDATA) | (ra == ccx_pkg::A_WATCHDOG) | (ra == ccx_pkg::A_FADDR);
    wire [31:0]  rd_mux   = (ra == ccx_pkg::A_INSTR)  ? {18'h0, ir_r} :
                            (ra == ccx_pkg::A_ACC)    ? {24'h0, acc_r} :
                            (ra == ccx_pkg::A_LATCH)  ? {25'h0, latch_r} :
                            (ra == ccx_pkg::A_PTR)    ? {17'h0, ptr_r} :
                            (ra == ccx_pkg::A_STATUS) ? status_w :
                            (ra == ccx_pkg::A_STACK)  ? {17'h0, stack_top_r} :
                            (ra == ccx_pkg::A_FDATA)  ? {24'h0, freg_r[faddr_r]} :
                            (ra == ccx_pkg::A_WATCHDOG) ? {16'h0, watchdog_count} :
                            (ra == ccx_pkg::A_FADDR)  ? {25'h0, faddr_r} : 32'h0;

    assign o_arready = ~rvalid_r;
    assign o_rvalid  = rvalid_r;
    assign o_rdata   = rdata_r;
    assign o_rresp   = rresp_r;
    assign o_instruction_pointer = ptr_r;
    assign o_busy    = ~wr_idle;

    // write channel bookkeeping
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h0;
            wstrb_r  <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= ccx_pkg::RESP_OK;
        end else begin
            if (aw_hs)
                awaddr_r <= i_awaddr;
            if (w_hs) begin
                wdata_r <= i_wdata;
                wstrb_r <= i_wstrb;
            end
            if (wr_take) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wa_ok ? ccx_pkg::RESP_OK : ccx_pkg::RESP_ERR;
            end else begin
                aw_got_r <= aw_have;
                w_got_r  <= w_have;
                if (bvalid_r & i_bready)
                    bvalid_r <= 1'b0;
            end
        end
    end

    // read channel
    // data is captured at acceptance so it stands while rvalid waits
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0;
            rresp_r  <= ccx_pkg::RESP_OK;
        end else if (ar_hs) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= ra_ok ? ccx_pkg::RESP_OK : ccx_pkg::RESP_ERR;
        end else if (rvalid_r & i_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // sequencer: idle, one execute cycle, second cycle for calls
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= CCX_IDLE;
            ir_r <= 14'h0000;
        end else begin
            case (st_r)
                CCX_IDLE: begin
                    if (wr_do & wa_instr) begin
                        ir_r <= wd[13:0];
                        st_r <= CCX_EXEC;
                    end
                end
                CCX_EXEC: st_r <= is_any_call ? CCX_CALL2 : CCX_IDLE;
                CCX_CALL2: st_r <= CCX_IDLE;
                default: st_r <= CCX_IDLE;
            endcase
        end
    end

    // pointer and return stack top; calls touch no flag
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ptr_r <= 15'h0000;
            stack_top_r <= 15'h0000;
        end else if (exec_go) begin
            if (is_any_call)
                stack_top_r <= ptr_r + 15'h0001;
            if (is_call)
                ptr_r <= call_tgt;
            else if (is_call_acc)
                ptr_r <= call_acc_tgt;
            // every other opcode, known or not, steps the pointer by one
            else
                ptr_r <= ptr_r + 15'h0001;
        end
    end

    // accumulator, latch and flags
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            acc_r   <= 8'h00;
            latch_r <= 7'h00;
            faddr_r <= 7'h00;
            z_r     <= 1'b0;
            expired_r <= 1'b1;
            sleep_r   <= 1'b1;
        end else begin
            if (wr_do & wa_acc & ws[0])
                acc_r <= wd[7:0];
            if (wr_do & wa_latch & ws[0])
                latch_r <= wd[6:0];
            if (wr_do & wa_faddr & ws[0])
                faddr_r <= wd[6:0];
            if (exec_go) begin
                // no event in this block clears these two flags
                // flags set by kick
                if (is_kick) begin
                    expired_r <= 1'b1;
                    sleep_r   <= 1'b1;
                end
                if (is_zacc) begin
                    acc_r <= 8'h00;
                    z_r   <= 1'b1;
                end
                if (is_zfile)
                    z_r <= 1'b1;
                if (fop) begin
                    z_r <= fop_res == 8'h00;
                    if (!to_file)
                        acc_r <= fop_res;
                end
            end
        end
    end

    // file registers; no reset, software loads them through the data window
    always_ff @(posedge i_mclk) begin
        if (wr_do & wa_fdata & ws[0])
            freg_r[faddr_r] <= wd[7:0];
        else if (exec_go & is_zfile)
            freg_r[f_idx] <= 8'h00;
        else if (exec_go & fop & to_file)
            freg_r[f_idx] <= fop_res;
    end

    // watchdog and prescaler cleared
    // an unkicked watchdog only counts; expiry takes no action here
    ccx_watchdog #(
        .PRE_W (8),
        .CNT_W (16)
    ) u_watchdog (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_clear   (kick),
        .o_count   (watchdog_count)
    );
endmodule : ccx_exec

// file: ccx_exec_monitor.sv
// checker for the executor's bus handshakes and execution timing
// assumes it is bound to ccx_exec and that issues arrive while idle
`timescale 1ns/10ps
module ccx_exec_monitor (
    input wire logic        i_mclk,
    input wire logic        i_reset_n,
    input wire logic [7:0]  i_awaddr,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic [7:0]  i_araddr,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0]  o_rresp,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic [14:0] o_instruction_pointer,
    input wire logic        o_busy
);
    logic [13:0] op_r;
    logic [14:0] ptr_r;
    logic [1:0]  len_r;
    // issues queued behind a busy core are not tracked
    wire         issue    = i_awvalid && o_awready && i_wvalid && o_wready && !o_busy
                            && i_awaddr == ccx_pkg::A_INSTR;
    wire         lit_call = (op_r & ccx_pkg::OP_CALL_MASK) == ccx_pkg::OP_CALL;
    wire         any_call = lit_call || op_r == ccx_pkg::OP_CALL_ACC;
    wire         far_rd   = i_arvalid && o_arready && i_araddr > ccx_pkg::A_FADDR;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            op_r  <= 14'h0;
            ptr_r <= 15'h0;
            len_r <= 2'h0;
        end else begin
            if (issue) begin
                op_r  <= i_wdata[13:0];
                ptr_r <= o_instruction_pointer;
            end
            len_r <= o_busy ? len_r + 2'h1 : 2'h0;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    a_write_answer: assert property (issue |=> o_bvalid && o_bresp == ccx_pkg::RESP_OK)
        else $error("issue not answered");
    a_bresp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    a_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read not answered");
    a_unmapped_read: assert property (far_rd |=> o_rresp == ccx_pkg::RESP_ERR && o_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_resp_blocks_req: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write taken while response pending");
    a_call_target: assert property ($fell(o_busy) && lit_call |->
        o_instruction_pointer[10:0] == op_r[10:0]) else $error("call target wrong");
    a_exec_length: assert property ($fell(o_busy) |-> len_r == (any_call ? 2'h2 : 2'h1))
        else $error("execution length wrong");
    a_pointer_step: assert property ($fell(o_busy) && !any_call |-> o_instruction_pointer == ptr_r + 15'h1)
        else $error("pointer not advanced by one");
    c_lit_call: cover property ($fell(o_busy) && lit_call);
    c_acc_call: cover property ($fell(o_busy) && any_call && !lit_call);
    c_far_read: cover property (far_rd);
endmodule : ccx_exec_monitor

bind ccx_exec ccx_exec_monitor u_monitor (.*);

// file: testbench.sv
// self-checking bench driving the executor's axi4-lite port directly
// assumes default parameters; registers are preloaded before every issue
`timescale 1ns/10ps
module testbench;
    logic        i_mclk = 1'b0, i_reset_n = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0;
    logic        i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic [7:0]  i_awaddr = 8'h0, i_araddr = 8'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, seed = 32'h8d1b;
    logic [3:0]  i_wstrb = 4'hf;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_busy, z;
    logic [1:0]  o_bresp, o_rresp;
    logic [14:0] o_instruction_pointer, p, ret;
    logic [7:0]  acc, f;
    logic [6:0]  lat, fa;
    int          failures = 0, comparisons = 0, cyc = 0, k;

    ccx_exec i_dut (.*);

    always #5 i_mclk = ~i_mclk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // predicted core state after one instruction; returns its encoding
    function automatic logic [13:0] step(input int kind, input logic [31:0] v);
        logic [13:0] op;
        logic [7:0]  r;
        case (kind)
            0: begin
                op  = ccx_pkg::OP_CALL | {3'h0, v[10:0]};
                ret = p + 15'h1;
                p   = {lat[6:3], v[10:0]};
            end
            1: begin
                op  = ccx_pkg::OP_CALL_ACC;
                ret = p + 15'h1;
                p   = {lat, acc};
            end
            2: op = ccx_pkg::OP_WDKICK;
            3: begin
                op  = ccx_pkg::OP_ZACC | {7'h0, v[6:0]};
                acc = 8'h0;
                z   = 1'b1;
            end
            4: begin
                op = ccx_pkg::OP_ZFILE | {7'h0, fa};
                f  = 8'h0;
                z  = 1'b1;
            end
            default: begin
                op = (kind == 5 ? ccx_pkg::OP_INV : ccx_pkg::OP_DEC) | {6'h0, v[7], fa};
                r  = kind == 5 ? ~f : f - 8'h1;
                z  = r == 8'h0;
                if (v[7]) f = r;
                else acc = r;
            end
        endcase
        if (kind > 1) p = p + 15'h1;
        return op;
    endfunction : step

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_mclk);
        i_awaddr  <= a;
        i_wdata   <= d;
        i_awvalid <= 1'b1;
        i_wvalid  <= 1'b1;
        i_bready  <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (!o_bvalid);
        i_bready <= 1'b0;
        chk({30'h0, o_bresp}, {30'h0, er});
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge i_mclk);
        i_araddr  <= a;
        i_arvalid <= 1'b1;
        i_rready  <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid);
        i_rready <= 1'b0;
        chk(o_rdata, e);
        chk({30'h0, o_rresp}, {30'h0, er});
    endtask : rc

    task automatic conclude();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // a hang costs at most this many cycles; the full run needs about 2250
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        repeat (8) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        p = 15'h0;
        z = 1'b0;
        rc(ccx_pkg::A_STATUS, 32'h18, ccx_pkg::RESP_OK);
        rc(ccx_pkg::A_PTR, 32'h0, ccx_pkg::RESP_OK);
        rc(8'h40, 32'h0, ccx_pkg::RESP_ERR);
        wr(8'h40, 32'h0, ccx_pkg::RESP_ERR);
        wr(ccx_pkg::A_PTR, 32'h0, ccx_pkg::RESP_ERR);
        for (int i = 0; i < 70; i++) begin
            k   = i % 7;
            acc = 8'(rnd());
            lat = 7'(rnd());
            fa  = 7'(rnd());
            f   = i < 7 ? (k == 6 ? 8'h01 : 8'hff) : (i < 14 ? 8'h00 : 8'(rnd()));
            wr(ccx_pkg::A_ACC, {24'h0, acc}, ccx_pkg::RESP_OK);
            wr(ccx_pkg::A_LATCH, {25'h0, lat}, ccx_pkg::RESP_OK);
            wr(ccx_pkg::A_FADDR, {25'h0, fa}, ccx_pkg::RESP_OK);
            wr(ccx_pkg::A_FDATA, {24'h0, f}, ccx_pkg::RESP_OK);
            wr(ccx_pkg::A_INSTR, {18'h0, step(k, rnd())}, ccx_pkg::RESP_OK);
            while (o_busy) @(posedge i_mclk);
            if (k == 2) rc(ccx_pkg::A_WATCHDOG, 32'h0, ccx_pkg::RESP_OK);
            rc(ccx_pkg::A_PTR, {17'h0, p}, ccx_pkg::RESP_OK);
            chk({17'h0, o_instruction_pointer}, {17'h0, p});
            rc(ccx_pkg::A_STACK, {17'h0, ret}, ccx_pkg::RESP_OK);
            rc(ccx_pkg::A_ACC, {24'h0, acc}, ccx_pkg::RESP_OK);
            rc(ccx_pkg::A_FDATA, {24'h0, f}, ccx_pkg::RESP_OK);
            rc(ccx_pkg::A_STATUS, {27'h0, 2'h3, z, 2'h0}, ccx_pkg::RESP_OK);
        end
        conclude();
    end
endmodule : testbench
